// file: inc/ostm_consts.svh
`ifndef OSTM_CONSTS_SVH
`define OSTM_CONSTS_SVH
`define OSTM_ADDR_W 4
`define OSTM_OFF_COUNT 4'h0
`define OSTM_OFF_RELOAD 4'h4
`define OSTM_OFF_CTRL 4'h8
`define OSTM_OFF_SWI 4'hc
`define OSTM_BIT_ENABLE 0
`define OSTM_BIT_AUTO 1
`define OSTM_BIT_START 2
`define OSTM_BIT_DBG_EN 3
`define OSTM_BIT_FW_HALT 4
`define OSTM_ZERO32 32'h0000_0000
`define OSTM_ONE32 32'h0000_0001
`define OSTM_SWI_W 4
`endif

// file: inc/ostm_pkg.sv
package ostm_pkg;
    // Control register fields
    typedef struct packed {
        logic fw_halt;
        logic dbg_en;
        logic start;
        logic auto_reload;
        logic enable;
    } ostm_ctrl_s;
    // Register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ostm_req_s;
endpackage

// file: src/ostm_timer.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`include "ostm_consts.svh"
module ostm_timer
    import ostm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire ostm_req_s bus_req,
    output logic [31:0] rd_data,
    input wire logic debug_halt,
    input wire logic lp_req,
    output logic lp_grant,
    output logic tick_irq,
    output logic [`OSTM_SWI_W-1:0] soft_irq
);
    logic [31:0] count_q;
    logic [31:0] reload_q;
    ostm_ctrl_s ctrl_q;
    logic [31:0] rd_data_q;
    logic tick_q;
    logic [`OSTM_SWI_W-1:0] swi_q;
    logic wr_count, wr_reload, wr_ctrl, wr_swi;
    logic paused, running, terminal;
    ostm_ctrl_s wctrl;

    // Address decode
    assign wr_count = bus_req.wr && (bus_req.addr == `OSTM_OFF_COUNT);
    assign wr_reload = bus_req.wr && (bus_req.addr == `OSTM_OFF_RELOAD);
    assign wr_ctrl = bus_req.wr && (bus_req.addr == `OSTM_OFF_CTRL);
    assign wr_swi = bus_req.wr && (bus_req.addr == `OSTM_OFF_SWI);
    assign wctrl = bus_req.wdata[`OSTM_BIT_FW_HALT:`OSTM_BIT_ENABLE];

    // Freeze, run and terminal-count conditions
    assign paused = ctrl_q.fw_halt || (ctrl_q.dbg_en && debug_halt);
    assign running = ctrl_q.enable && ctrl_q.start && (count_q != `OSTM_ZERO32);
    assign terminal = running && !paused && (count_q == `OSTM_ONE32);

    // Control register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ctrl_q <= '0;
        end else if (wr_ctrl) begin
            if (!wctrl.enable) begin
                ctrl_q <= '0;
            end else begin
                ctrl_q <= wctrl;
                if (wctrl.start && reload_q == `OSTM_ZERO32) begin
                    ctrl_q.start <= 1'b0;
                end
            end
        end else if (!ctrl_q.enable) begin
            ctrl_q <= '0;
        end else if (terminal && !ctrl_q.auto_reload) begin
            ctrl_q.start <= 1'b0;
        end
    end

    // Reload register
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !ctrl_q.enable) begin
            reload_q <= `OSTM_ZERO32;
        end else if (wr_reload) begin
            reload_q <= bus_req.wdata;
        end
    end

    // Down counter
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            count_q <= `OSTM_ZERO32;
        end else if (wr_ctrl) begin
            if (wctrl.enable && wctrl.start && !ctrl_q.start) begin
                count_q <= reload_q;
            end else if (!wctrl.enable || !wctrl.start) begin
                count_q <= `OSTM_ZERO32;
            end
        end else if (!ctrl_q.enable) begin
            count_q <= `OSTM_ZERO32;
        end else if (wr_count) begin
            count_q <= bus_req.wdata;
        end else if (terminal) begin
            count_q <= ctrl_q.auto_reload ? reload_q : `OSTM_ZERO32;
        end else if (running && !paused) begin
            count_q <= count_q - `OSTM_ONE32;
        end
    end

    // Tick event and software interrupt pulses
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tick_q <= 1'b0;
            swi_q <= '0;
        end else begin
            tick_q <= terminal && !wr_ctrl;
            swi_q <= wr_swi ? bus_req.wdata[`OSTM_SWI_W-1:0] : '0;
        end
    end
    assign tick_irq = tick_q;
    assign soft_irq = swi_q;
    assign lp_grant = lp_req && !(ctrl_q.enable && ctrl_q.start);

    // Read data, valid the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rd_data_q <= `OSTM_ZERO32;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                `OSTM_OFF_COUNT: rd_data_q <= count_q;
                `OSTM_OFF_RELOAD: rd_data_q <= reload_q;
                `OSTM_OFF_CTRL: rd_data_q <= {27'h000_0000, ctrl_q};
                default: rd_data_q <= `OSTM_ZERO32;
            endcase
        end else begin
            rd_data_q <= `OSTM_ZERO32;
        end
    end
    assign rd_data = rd_data_q;

    // Properties sample on the timer clock and are off during reset, except p_reset_state, which checks the reset itself
    // Assertions: tick event
    property p_tick_from_one;
        @(posedge ref_clk) disable iff (!rst_b)
        tick_irq |-> $past(count_q) == `OSTM_ONE32;
    endproperty
    a_tick_from_one: assert property (p_tick_from_one) else $error("tick without 1-to-0 step");
    property p_tick_made;
        @(posedge ref_clk) disable iff (!rst_b)
        (terminal && !wr_ctrl) |=> tick_irq;
    endproperty
    a_tick_made: assert property (p_tick_made) else $error("1-to-0 step without tick");
    property p_tick_source;
        @(posedge ref_clk) disable iff (!rst_b)
        tick_irq |-> ($past(terminal) && !$past(wr_ctrl));
    endproperty
    a_tick_source: assert property (p_tick_source) else $error("tick without running count");
    property p_stop_quiet;
        @(posedge ref_clk) disable iff (!rst_b)
        wr_ctrl |=> !tick_irq;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("tick after control write");

    // Assertions: one-shot and continuous runs
    property p_oneshot_stop;
        @(posedge ref_clk) disable iff (!rst_b)
        (terminal && !ctrl_q.auto_reload && !bus_req.wr) |=> (count_q == `OSTM_ZERO32 && !ctrl_q.start);
    endproperty
    a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot did not stop");
    property p_auto_reload;
        @(posedge ref_clk) disable iff (!rst_b)
        (terminal && ctrl_q.auto_reload && !bus_req.wr) |=> count_q == $past(reload_q);
    endproperty
    a_auto_reload: assert property (p_auto_reload) else $error("no auto reload");
    property p_load_start;
        @(posedge ref_clk) disable iff (!rst_b)
        (wr_ctrl && wctrl.enable && wctrl.start && !ctrl_q.start) |=> count_q == $past(reload_q);
    endproperty
    a_load_start: assert property (p_load_start) else $error("start did not load reload value");
    property p_start_set;
        @(posedge ref_clk) disable iff (!rst_b)
        (wr_ctrl && wctrl.enable && wctrl.start && reload_q != `OSTM_ZERO32) |=> ctrl_q.start;
    endproperty
    a_start_set: assert property (p_start_set) else $error("launch not taken");
    property p_start_zero;
        @(posedge ref_clk) disable iff (!rst_b)
        (wr_ctrl && wctrl.start && reload_q == `OSTM_ZERO32) |=> !ctrl_q.start;
    endproperty
    a_start_zero: assert property (p_start_zero) else $error("started with zero reload");
    property p_stop_clear;
        @(posedge ref_clk) disable iff (!rst_b)
        (wr_ctrl && !wctrl.start) |=> (count_q == `OSTM_ZERO32 && !ctrl_q.start);
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear count");

    // Assertions: freezing, resuming and counting
    property p_pause_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        (ctrl_q.fw_halt && !bus_req.wr) |=> $stable(count_q);
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("count moved while paused");
    property p_dbg_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        (ctrl_q.dbg_en && debug_halt && !bus_req.wr) |=> $stable(count_q);
    endproperty
    a_dbg_hold: assert property (p_dbg_hold) else $error("count moved in debug halt");
    property p_dbg_ignored;
        @(posedge ref_clk) disable iff (!rst_b)
        (!ctrl_q.dbg_en && !ctrl_q.fw_halt && running && count_q > `OSTM_ONE32 && !bus_req.wr)
            |=> count_q == $past(count_q) - `OSTM_ONE32;
    endproperty
    a_dbg_ignored: assert property (p_dbg_ignored) else $error("halt obeyed while not enabled");
    property p_resume;
        @(posedge ref_clk) disable iff (!rst_b)
        (ctrl_q.fw_halt && !bus_req.wr) |=> ctrl_q.start == $past(ctrl_q.start);
    endproperty
    a_resume: assert property (p_resume) else $error("pause lost the run");
    property p_decrement;
        @(posedge ref_clk) disable iff (!rst_b)
        (running && !paused && count_q > `OSTM_ONE32 && !bus_req.wr) |=> count_q == $past(count_q) - `OSTM_ONE32;
    endproperty
    a_decrement: assert property (p_decrement) else $error("no decrement");
    property p_hold_idle;
        @(posedge ref_clk) disable iff (!rst_b)
        (ctrl_q.enable && !ctrl_q.start && !bus_req.wr) |=> $stable(count_q);
    endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("count moved while stopped");
    property p_count_step;
        @(posedge ref_clk) disable iff (!rst_b)
        (running && !paused && !bus_req.wr) |=> (count_q < $past(count_q) || count_q == $past(reload_q));
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not step down");

    // Assertions: registers, reset and disable
    property p_reload_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        (ctrl_q.enable && !wr_reload) |=> $stable(reload_q);
    endproperty
    a_reload_hold: assert property (p_reload_hold) else $error("reload value moved");
    property p_reload_write;
        @(posedge ref_clk) disable iff (!rst_b)
        (wr_reload && ctrl_q.enable) |=> reload_q == $past(bus_req.wdata);
    endproperty
    a_reload_write: assert property (p_reload_write) else $error("reload write lost");
    property p_rd_reload;
        @(posedge ref_clk) disable iff (!rst_b)
        (bus_req.rd && bus_req.addr == `OSTM_OFF_RELOAD) |=> rd_data == $past(reload_q);
    endproperty
    a_rd_reload: assert property (p_rd_reload) else $error("reload read wrong");
    property p_count_write;
        @(posedge ref_clk) disable iff (!rst_b)
        (wr_count && ctrl_q.enable) |=> count_q == $past(bus_req.wdata);
    endproperty
    a_count_write: assert property (p_count_write) else $error("count write lost");
    property p_rd_count;
        @(posedge ref_clk) disable iff (!rst_b)
        (bus_req.rd && bus_req.addr == `OSTM_OFF_COUNT) |=> rd_data == $past(count_q);
    endproperty
    a_rd_count: assert property (p_rd_count) else $error("count read wrong");
    property p_rd_idle;
        @(posedge ref_clk) disable iff (!rst_b)
        !bus_req.rd |=> rd_data == `OSTM_ZERO32;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_disable;
        @(posedge ref_clk) disable iff (!rst_b)
        !ctrl_q.enable |=> ##1 (count_q == `OSTM_ZERO32 || bus_req.wr || $past(bus_req.wr));
    endproperty
    a_disable: assert property (p_disable) else $error("disabled count not cleared");
    property p_disable_regs;
        @(posedge ref_clk) disable iff (!rst_b)
        (!ctrl_q.enable && !bus_req.wr) |=> (reload_q == `OSTM_ZERO32 && count_q == `OSTM_ZERO32 && ctrl_q == '0);
    endproperty
    a_disable_regs: assert property (p_disable_regs) else $error("disabled registers not at default");
    property p_reset_state;
        @(posedge ref_clk)
        !rst_b |=> (count_q == `OSTM_ZERO32 && reload_q == `OSTM_ZERO32 && ctrl_q == '0 && !tick_irq);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset left state behind");

    // Assertions: side outputs
    property p_lp;
        @(posedge ref_clk) disable iff (!rst_b)
        lp_grant |-> !ctrl_q.start;
    endproperty
    a_lp: assert property (p_lp) else $error("low power granted while active");
    property p_lp_grant;
        @(posedge ref_clk) disable iff (!rst_b)
        (lp_req && !ctrl_q.start) |-> lp_grant;
    endproperty
    a_lp_grant: assert property (p_lp_grant) else $error("low power refused while inactive");
    property p_swi;
        @(posedge ref_clk) disable iff (!rst_b)
        wr_swi |=> soft_irq == $past(bus_req.wdata[`OSTM_SWI_W-1:0]);
    endproperty
    a_swi: assert property (p_swi) else $error("software interrupt lost");
    property p_swi_idle;
        @(posedge ref_clk) disable iff (!rst_b)
        !wr_swi |=> soft_irq == '0;
    endproperty
    a_swi_idle: assert property (p_swi_idle) else $error("software interrupt without write");

    // Main scenarios reached
    c_tick: cover property (@(posedge ref_clk) disable iff (!rst_b) tick_irq);
    c_reload: cover property (@(posedge ref_clk) disable iff (!rst_b) terminal && ctrl_q.auto_reload);
    c_pause: cover property (@(posedge ref_clk) disable iff (!rst_b) running && paused);
    c_oneshot: cover property (@(posedge ref_clk) disable iff (!rst_b) terminal && !ctrl_q.auto_reload);
endmodule

// file: test/tb.sv
`timescale 1ns/1ns
`include "ostm_consts.svh"
module tb
    import ostm_pkg::*;
;
    logic ref_clk = 0;
    logic rst_b = 0;
    ostm_req_s bus_req = '0;
    logic debug_halt = 0;
    logic lp_req = 1;
    logic [31:0] rd_data, v, w;
    logic lp_grant, tick_irq;
    logic [3:0] soft_irq;
    int error_cnt = 0;
    int comparisons = 0;
    int n, m, p, k;
    // Cycle model state
    logic [31:0] mc, mr, om;
    ostm_ctrl_s mk, ok, nc;
    logic mtick, halt_m, live_m, term_m, wc_m;
    logic [3:0] mswi;
    logic [31:0] rdq[$];
    // Free-running bench clock
    always #20 ref_clk = ~ref_clk;
    ostm_timer i_ostm_timer (.ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
        .debug_halt(debug_halt), .lp_req(lp_req), .lp_grant(lp_grant), .tick_irq(tick_irq), .soft_irq(soft_irq));
    // Verdict and end of run
    task automatic final_report();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Compare against the expected value
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bus write and read, one-cycle strobes
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask
    task automatic rd(logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        #1 d = rd_data;
    endtask
    // Count edges until a tick, bounded; a missing or stray tick is a mismatch
    task automatic tk(int lim, bit want, output int c);
        c = 0;
        do begin
            @(posedge ref_clk);
            #1 c++;
        end while (tick_irq !== 1'b1 && c < lim);
        chk(32'(tick_irq === 1'b1), 32'(want));
        if (want && tick_irq !== 1'b1) final_report();
    endtask
    // Cycle model: checks what the last edge produced, then steps its own state
    always @(posedge ref_clk) begin
        if (rst_b && rdq.size() > 0) begin
            chk(rd_data, rdq.pop_front());
            chk(32'(tick_irq), 32'(mtick));
            chk(32'(soft_irq), 32'(mswi));
            chk(32'(lp_grant), 32'(lp_req && !(mk.enable && mk.start)));
        end
        ok = mk;
        om = mr;
        nc = bus_req.wdata[`OSTM_BIT_FW_HALT:`OSTM_BIT_ENABLE];
        wc_m = bus_req.wr && bus_req.addr == `OSTM_OFF_CTRL;
        halt_m = ok.fw_halt || (ok.dbg_en && debug_halt);
        live_m = ok.enable && ok.start && mc != 0;
        term_m = live_m && !halt_m && mc == 1;
        mtick = rst_b && term_m && !wc_m;
        mswi = (rst_b && bus_req.wr && bus_req.addr == `OSTM_OFF_SWI) ? bus_req.wdata[3:0] : 4'h0;
        if (!rst_b) rdq.delete();
        if (!rst_b || !bus_req.rd) rdq.push_back(0);
        else if (bus_req.addr == `OSTM_OFF_COUNT) rdq.push_back(mc);
        else if (bus_req.addr == `OSTM_OFF_RELOAD) rdq.push_back(om);
        else if (bus_req.addr == `OSTM_OFF_CTRL) rdq.push_back({27'h000_0000, ok});
        else rdq.push_back(0);
        if (!rst_b) mc = 0;
        else if (wc_m) begin
            if (nc.enable && nc.start && !ok.start) mc = om;
            else if (!nc.enable || !nc.start) mc = 0;
        end else if (!ok.enable) mc = 0;
        else if (bus_req.wr && bus_req.addr == `OSTM_OFF_COUNT) mc = bus_req.wdata;
        else if (term_m) mc = ok.auto_reload ? om : 0;
        else if (live_m && !halt_m) mc = mc - 1;
        if (!rst_b || !ok.enable) mr = 0;
        else if (bus_req.wr && bus_req.addr == `OSTM_OFF_RELOAD) mr = bus_req.wdata;
        if (!rst_b || (wc_m && !nc.enable) || (!wc_m && !ok.enable)) mk = '0;
        else if (wc_m) begin
            mk = nc;
            mk.start = nc.start && om != 0;
        end else if (term_m && !ok.auto_reload) mk.start = 1'b0;
    end
    // Main sequence
    initial begin
        void'($urandom(32'h8890));
        repeat (16) @(posedge ref_clk);
        rst_b <= 1;
        for (int i = 0; i < 4; i++) begin
            rd(4'(i * 4), v); chk(v, 0);
        end
        rd(4'h2, v); chk(v, 0);
        wr(`OSTM_OFF_RELOAD, 32'h0000_0009);
        rd(`OSTM_OFF_RELOAD, v); chk(v, 0);
        wr(`OSTM_OFF_CTRL, 32'h0000_0005);
        rd(`OSTM_OFF_CTRL, v); chk(v, 32'h0000_0001);
        tk(20, 0, k);
        wr(`OSTM_OFF_COUNT, 32'h1234_5678);
        rd(`OSTM_OFF_COUNT, v); chk(v, 32'h1234_5678);
        // One-shot run with a random reload
        n = 3 + $urandom % 20;
        m = n + 40;
        wr(`OSTM_OFF_RELOAD, 32'(n));
        wr(`OSTM_OFF_CTRL, 32'h0000_0005);
        #1 chk(32'(lp_grant), 0);
        tk(64, 1, p); chk(32'(p), 32'(n));
        rd(`OSTM_OFF_CTRL, v); chk(v, 32'h0000_0001);
        rd(`OSTM_OFF_COUNT, v); chk(v, 0);
        chk(32'(lp_grant), 1);
        tk(2 * n, 0, k);
        // Continuous run, reload changed mid-period
        wr(`OSTM_OFF_CTRL, 32'h0000_0007);
        tk(64, 1, k);
        tk(64, 1, k); chk(32'(k == n || k == n + 1), 1);
        wr(`OSTM_OFF_RELOAD, 32'(m));
        tk(64, 1, k); chk(32'(k <= n), 1);
        tk(128, 1, k); chk(32'(k == m || k == m + 1), 1);
        // Software pause then resume
        wr(`OSTM_OFF_CTRL, 32'h0000_0017);
        rd(`OSTM_OFF_COUNT, v);
        repeat (5) @(posedge ref_clk);
        rd(`OSTM_OFF_COUNT, w); chk(w, v);
        wr(`OSTM_OFF_CTRL, 32'h0000_0007);
        rd(`OSTM_OFF_COUNT, v); chk(32'(w - v < 8), 1);
        // Debug halt honoured only when enabled
        wr(`OSTM_OFF_CTRL, 32'h0000_000f);
        debug_halt <= 1;
        rd(`OSTM_OFF_COUNT, v);
        repeat (4) @(posedge ref_clk);
        rd(`OSTM_OFF_COUNT, w); chk(w, v);
        wr(`OSTM_OFF_CTRL, 32'h0000_0007);
        rd(`OSTM_OFF_COUNT, v); chk(32'(v != w), 1);
        debug_halt <= 0;
        // Stop by clearing launch, then disable
        wr(`OSTM_OFF_CTRL, 32'h0000_0001);
        rd(`OSTM_OFF_COUNT, v); chk(v, 0);
        tk(2 * m, 0, k);
        wr(`OSTM_OFF_CTRL, 32'h0000_0000);
        rd(`OSTM_OFF_RELOAD, v); chk(v, 0);
        wr(`OSTM_OFF_SWI, 32'h0000_000a);
        #1 chk(32'(soft_irq), 32'h0000_000a);
        // Reset in mid-run
        wr(`OSTM_OFF_CTRL, 32'h0000_0001);
        wr(`OSTM_OFF_RELOAD, 32'h0000_0032);
        wr(`OSTM_OFF_CTRL, 32'h0000_0005);
        @(posedge ref_clk);
        rst_b <= 0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1;
        rd(`OSTM_OFF_RELOAD, v); chk(v, 0);
        rd(`OSTM_OFF_CTRL, v); chk(v, 0);
        final_report();
    end
endmodule
